// File: core/pioa_port.sv
// Port A: eight-bit I/O port with address output and interrupt input functions
// What this block does
// - direction register eight bits, write-only, reads undefined
// - direction cleared by power-on and hardware standby
// - modes 1-3,7: direction one output, zero input
// - modes 4,5: pins 4..0 always address outputs
// - modes 4,5: pins 7..5 address per direction
// - mode 6: address output per direction bit
// - standby keep bit holds or floats address pins
// - output latch read/write, cleared by hard resets
// - pin-state register read-only, writes ignored
// - pin-state read: latch if output, else pin
// - pin-state frozen in manual reset, software standby, except during hardware standby
// - pull-up on when input and enable set, modes 1-7
// - modes 4,5 only pull-ups 7..5 work
// - pull-up enables cleared by hard resets only
// - pins feed interrupt requests four to seven
// - registers decoded at fixed 16-bit offsets
// - open-drain select disables high side, modes 1-3,7
// - open-drain select cleared by hard resets only
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
`include "pioa_consts.svh"

module pioa_port #(
   parameter int PORT_W = 8
) (
   // Clock and power-on reset
   input wire logic CLK,
   input wire logic RST,
   // Chip state: mode and resets/standby
   input wire pioa_pkg::pioa_mode_t MODE,
   input wire logic MAN_RST,
   input wire logic SW_STBY,
   input wire logic STBY_OUT_KEEP,
   input wire logic HW_STBY_PIN,
   // Register port
   input wire pioa_pkg::pioa_addr_t ADDR,
   input wire pioa_pkg::pioa_byte_t WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [7:0] RDATA,
   // Address lines from the bus controller
   input wire logic [PORT_W-1:0] ADDR_BUS_IN,
   // Port pins
   input wire logic [PORT_W-1:0] PIN_IN,
   output logic [PORT_W-1:0] PIN_OUT,
   output logic [PORT_W-1:0] PIN_OE,
   output logic [PORT_W-1:0] PULLUP_ON,
   // Interrupt request levels four to seven
   output logic [3:0] IRQ_LEVEL
);
   import pioa_pkg::*;

   if (PORT_W != 8) begin : g_bad_width
      $error("pioa_port serves only an eight-bit port");
   end

   logic [PORT_W-1:0] dir_r;
   logic [PORT_W-1:0] latch_r;
   logic [PORT_W-1:0] pullup_r;
   logic [PORT_W-1:0] odrain_r;
   logic [PORT_W-1:0] level_r;
   logic [PORT_W-1:0] level_nxt;
   logic [PORT_W-1:0] pin_meta_r;
   logic [PORT_W-1:0] pin_sync_r;
   logic hw_meta_r;
   logic hw_stby_r;
   logic [PORT_W-1:0] out_nxt;
   logic [PORT_W-1:0] oe_nxt;
   logic [PORT_W-1:0] pull_nxt;
   logic [7:0] rdata_nxt;
   logic hit_dir;
   logic hit_level;
   logic hit_latch;
   logic hit_pullup;
   logic hit_odrain;
   pioa_mode_cls_t cls;

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         pin_meta_r <= '0;
         pin_sync_r <= '0;
      end else begin
         pin_meta_r <= PIN_IN;
         pin_sync_r <= pin_meta_r;
      end
   end

   // Standby pin is asynchronous too
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         hw_meta_r <= 1'b0;
         hw_stby_r <= 1'b0;
      end else begin
         hw_meta_r <= HW_STBY_PIN;
         hw_stby_r <= hw_meta_r;
      end
   end

   // Mode 0, the only code left to the default branch, leaves the port an input with no pull-ups
   always_comb begin
      case (MODE)
         3'd1, 3'd2, 3'd3, 3'd7: cls = PIOA_CLS_GPIO;
         3'd4, 3'd5: cls = PIOA_CLS_ADDR_LOW;
         3'd6: cls = PIOA_CLS_ADDR_ALL;
         default: cls = PIOA_CLS_NONE;
      endcase
   end

   assign hit_dir = (ADDR == `PIOA_OFF_DIR);
   assign hit_level = (ADDR == `PIOA_OFF_LEVEL);
   assign hit_latch = (ADDR == `PIOA_OFF_LATCH);
   assign hit_pullup = (ADDR == `PIOA_OFF_PULLUP);
   assign hit_odrain = (ADDR == `PIOA_OFF_ODRAIN);

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         dir_r <= `PIOA_RST_DIR;
      end else if (hw_stby_r) begin
         dir_r <= `PIOA_RST_DIR;
      end else if (WR && hit_dir) begin
         dir_r <= WDATA;
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         latch_r <= `PIOA_RST_LATCH;
      end else if (hw_stby_r) begin
         latch_r <= `PIOA_RST_LATCH;
      end else if (WR && hit_latch) begin
         latch_r <= WDATA;
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         pullup_r <= `PIOA_RST_PULLUP;
      end else if (hw_stby_r) begin
         pullup_r <= `PIOA_RST_PULLUP;
      end else if (WR && hit_pullup) begin
         pullup_r <= WDATA;
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         odrain_r <= `PIOA_RST_ODRAIN;
      end else if (hw_stby_r) begin
         odrain_r <= `PIOA_RST_ODRAIN;
      end else if (WR && hit_odrain) begin
         odrain_r <= WDATA;
      end
   end

   // output bits show latch, input bits the pin
   assign level_nxt = (dir_r & latch_r) | (~dir_r & pin_sync_r);

   // frozen while manual reset or software standby holds, except during hardware standby
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         level_r <= '0;
      end else if (hw_stby_r || !(MAN_RST || SW_STBY)) begin
         level_r <= level_nxt;
      end
   end

   // direction reads back undefined; no read path
   always_comb begin
      if (hit_dir) begin
         rdata_nxt = `PIOA_DIR_RD_VAL;
      end else if (hit_level) begin
         rdata_nxt = level_r;
      end else if (hit_latch) begin
         rdata_nxt = latch_r;
      end else if (hit_pullup) begin
         rdata_nxt = pullup_r;
      end else if (hit_odrain) begin
         rdata_nxt = odrain_r;
      end else begin
         rdata_nxt = `PIOA_UNMAPPED_RD;
      end
   end

   // Read data stand only in the cycle after the strobe
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         RDATA <= 8'h00;
      end else if (RD) begin
         RDATA <= rdata_nxt;
      end else begin
         RDATA <= 8'h00;
      end
   end

   for (genvar i = 0; i < PORT_W; i++) begin : g_pin
      logic addr_sel;
      logic gpio_sel;
      logic pull_ok;
      // low pins fixed address in modes 4,5
      assign addr_sel = ((cls == PIOA_CLS_ADDR_LOW) &&
                         ((i < `PIOA_ADDR_FIXED_W) || dir_r[i])) ||
                        ((cls == PIOA_CLS_ADDR_ALL) && dir_r[i]);
      assign gpio_sel = (cls == PIOA_CLS_GPIO) && dir_r[i];
      // low pull-ups off in modes 4,5
      assign pull_ok = (cls != PIOA_CLS_NONE) &&
                       !((cls == PIOA_CLS_ADDR_LOW) && (i < `PIOA_ADDR_FIXED_W));
      always_comb begin
         out_nxt[i] = latch_r[i];
         oe_nxt[i] = 1'b0;
         if (hw_stby_r) begin
            oe_nxt[i] = 1'b0;
         end else if (addr_sel) begin
            // standby keeps or floats address pins
            if (SW_STBY) begin
               out_nxt[i] = PIN_OUT[i];
               oe_nxt[i] = STBY_OUT_KEEP;
            end else begin
               out_nxt[i] = ADDR_BUS_IN[i];
               oe_nxt[i] = 1'b1;
            end
         end else if (gpio_sel) begin
            oe_nxt[i] = !(odrain_r[i] && latch_r[i]);
         end
      end
      assign pull_nxt[i] = !hw_stby_r && !dir_r[i] && pullup_r[i] && pull_ok;
   end

   // Pin drive registered so pins never glitch on mode or strobe changes
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         PIN_OUT <= '0;
         PIN_OE <= '0;
         PULLUP_ON <= '0;
      end else begin
         PIN_OUT <= out_nxt;
         PIN_OE <= oe_nxt;
         PULLUP_ON <= pull_nxt;
      end
   end

   // synchronised pins 7..4 feed the interrupt requests
   assign IRQ_LEVEL = pin_sync_r[`PIOA_IRQ_BASE +: 4];

   // Checks
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RST);

   a_dir_read_undef: assert property (
      RD && hit_dir |=> RDATA == `PIOA_DIR_RD_VAL)
      else $error("direction read did not return the undefined value");

   a_dir_hard_clear: assert property (
      hw_stby_r |=> dir_r == `PIOA_RST_DIR && latch_r == `PIOA_RST_LATCH)
      else $error("hardware standby did not clear direction and latch");

   a_dir_kept_manual: assert property (
      MAN_RST && !hw_stby_r && !WR |=> $stable(dir_r))
      else $error("manual reset changed direction register");

   a_gpio_drive: assert property (
      cls == PIOA_CLS_GPIO && !hw_stby_r && dir_r[0] && !odrain_r[0]
      |=> PIN_OE[0] && PIN_OUT[0] == $past(latch_r[0]))
      else $error("gpio output pin not driven from latch");

   a_addr_low_fixed: assert property (
      cls == PIOA_CLS_ADDR_LOW && !hw_stby_r && !SW_STBY
      |=> PIN_OE[4:0] == 5'h1F && PIN_OUT[4:0] == $past(ADDR_BUS_IN[4:0]))
      else $error("low pins not address outputs in modes 4 and 5");

   a_addr_high_dir: assert property (
      cls == PIOA_CLS_ADDR_LOW && !hw_stby_r && !SW_STBY
      |=> PIN_OE[7:5] == $past(dir_r[7:5]))
      else $error("high pins ignore direction in modes 4 and 5");

   a_mode6_dir: assert property (
      cls == PIOA_CLS_ADDR_ALL && !hw_stby_r && !SW_STBY |=> PIN_OE == $past(dir_r))
      else $error("mode 6 drive does not follow direction");

   a_stby_float: assert property (
      cls == PIOA_CLS_ADDR_ALL && SW_STBY && !STBY_OUT_KEEP && !hw_stby_r
      |=> PIN_OE == 8'h00)
      else $error("address pins not floated in standby");

   a_stby_hold: assert property (
      SW_STBY && STBY_OUT_KEEP && !hw_stby_r &&
      (cls == PIOA_CLS_ADDR_LOW || (cls == PIOA_CLS_ADDR_ALL && dir_r[0]))
      |=> $stable(PIN_OUT[0]))
      else $error("address pins not held in standby");

   a_latch_readback: assert property (
      WR && hit_latch && !hw_stby_r ##1 RD && hit_latch && !hw_stby_r
      |=> RDATA == $past(WDATA, 2))
      else $error("latch does not read back written value");

   a_level_no_write: assert property (
      WR && hit_level && !hw_stby_r
      |=> $stable(dir_r) && $stable(latch_r) && $stable(pullup_r) && $stable(odrain_r))
      else $error("write to pin-state register changed a register");

   a_level_mux: assert property (
      !MAN_RST && !SW_STBY |=> level_r == $past(level_nxt))
      else $error("pin-state register does not follow pins");

   a_level_frozen: assert property (
      (MAN_RST || SW_STBY) && !hw_stby_r |=> $stable(level_r))
      else $error("pin-state register changed while frozen");

   a_pull_rule: assert property (
      PULLUP_ON != 8'h00 |-> ($past(pullup_r) & ~$past(dir_r) & PULLUP_ON) == PULLUP_ON)
      else $error("pull-up on without enable or with output set");

   a_pull_low_off: assert property (
      cls == PIOA_CLS_ADDR_LOW |=> PULLUP_ON[4:0] == 5'h00)
      else $error("low pull-ups on in modes 4 and 5");

   a_irq_sync: assert property (
      1'b1 |-> ##2 IRQ_LEVEL == $past(PIN_IN[7:4], 2))
      else $error("interrupt levels not two cycles behind pins");

   a_odrain_high: assert property (
      cls == PIOA_CLS_GPIO && !hw_stby_r && dir_r[3] && odrain_r[3] && latch_r[3]
      |=> !PIN_OE[3])
      else $error("open-drain pin drove high");

   a_odrain_clear: assert property (
      hw_stby_r |=> odrain_r == `PIOA_RST_ODRAIN && pullup_r == `PIOA_RST_PULLUP)
      else $error("hardware standby did not clear open-drain and pull-up");

   c_gpio_out: cover property (WR && hit_dir ##1 WR && hit_latch ##2 PIN_OE != 8'h00);
   c_addr_mode: cover property (cls == PIOA_CLS_ADDR_LOW ##1 PIN_OE[4:0] == 5'h1F);
   c_stby_float: cover property (SW_STBY && !STBY_OUT_KEEP && cls == PIOA_CLS_ADDR_ALL);
   c_level_read: cover property (RD && hit_level ##1 RDATA != 8'h00);

endmodule
`default_nettype wire

// File: include/pioa_consts.svh
// Offsets, reset values and fixed figures of the port A block
`ifndef PIOA_CONSTS_SVH
`define PIOA_CONSTS_SVH

// Register offsets, lower 16 bits of the CPU address
`define PIOA_OFF_DIR 16'hFEB9
`define PIOA_OFF_LEVEL 16'hFF59
`define PIOA_OFF_LATCH 16'hFF69
`define PIOA_OFF_PULLUP 16'hFF70
`define PIOA_OFF_ODRAIN 16'hFF77

// Reset values of the writable registers
`define PIOA_RST_DIR 8'h00
`define PIOA_RST_LATCH 8'h00
`define PIOA_RST_PULLUP 8'h00
`define PIOA_RST_ODRAIN 8'h00

// Value returned by a read of the write-only direction register
`define PIOA_DIR_RD_VAL 8'hFF
// Value returned by a read of an unmapped address
`define PIOA_UNMAPPED_RD 8'h00

// Pins 4..0 are address outputs whatever their direction bit in modes 4 and 5
`define PIOA_ADDR_FIXED_W 5
// First pin that feeds an interrupt request line
`define PIOA_IRQ_BASE 4

`endif

// File: include/pioa_pkg.sv
// Types shared by the port A block
package pioa_pkg;

   // What the operating mode makes of the port pins
   typedef enum logic [1:0] {
      PIOA_CLS_NONE,
      PIOA_CLS_GPIO,
      PIOA_CLS_ADDR_LOW,
      PIOA_CLS_ADDR_ALL
   } pioa_mode_cls_t;

   typedef logic [2:0] pioa_mode_t;
   typedef logic [15:0] pioa_addr_t;
   typedef logic [7:0] pioa_byte_t;

endpackage

// File: testbench/pioa_pins_model.sv
// Far side of port A: outside drivers, pull-ups and floating pins
`timescale 1ns/1ns
`default_nettype none
module pioa_pins_model (
   // Clock
   input wire logic clk,
   // Port side
   input wire logic [7:0] pin_out,
   input wire logic [7:0] pin_oe,
   input wire logic [7:0] pullup_on,
   output logic [7:0] pin_in,
   // Outside drivers set by the bench
   input wire logic [7:0] ext_en,
   input wire logic [7:0] ext_val
);
   logic [7:0] flt_r = 8'h55;
   // A floating pin must not look stable, so it toggles every cycle
   always @(posedge clk) flt_r <= ~flt_r;
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (pin_oe[i]) pin_in[i] = pin_out[i];
         else if (ext_en[i]) pin_in[i] = ext_val[i];
         else if (pullup_on[i]) pin_in[i] = 1'b1;
         else pin_in[i] = flt_r[i];
      end
   end
endmodule
`default_nettype wire

// File: testbench/test_pioa_port.sv
// Self-checking bench for the port A block
`timescale 1ns/1ns
`default_nettype none
`include "pioa_consts.svh"
module test_pioa_port;
   import pioa_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   pioa_mode_t mode = 3'h0;
   logic man_rst = 1'b0;
   logic sw_stby = 1'b0;
   logic keep = 1'b0;
   logic hw_stby = 1'b0;
   pioa_addr_t addr = 16'h0000;
   pioa_byte_t wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic rd_d = 1'b0;
   logic [7:0] abus = 8'h00;
   logic [7:0] ext_en = 8'h00;
   logic [7:0] ext_val = 8'h00;
   logic [7:0] rdata, pin_in, pin_out, pin_oe, pu_on;
   logic [3:0] irq;
   logic [7:0] exp_q[$];
   logic [7:0] lat, v, w, eoe;
   logic ad;
   pioa_mode_t mt[7] = '{3'h1, 3'h2, 3'h3, 3'h7, 3'h4, 3'h5, 3'h6};
   int fail_count = 0;
   int samples_checked = 0;
   int cyc = 0;

   always #4 clk = ~clk;

   pioa_port u_pioa_port (.CLK(clk), .RST(rst), .MODE(mode), .MAN_RST(man_rst),
      .SW_STBY(sw_stby), .STBY_OUT_KEEP(keep), .HW_STBY_PIN(hw_stby), .ADDR(addr),
      .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .ADDR_BUS_IN(abus),
      .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe), .PULLUP_ON(pu_on),
      .IRQ_LEVEL(irq));
   pioa_pins_model u_pioa_pins_model (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
      .pullup_on(pu_on), .pin_in(pin_in), .ext_en(ext_en), .ext_val(ext_val));

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One register access; a read notes its expected data
   task automatic acc(input logic wn, input pioa_addr_t a, input logic [7:0] d);
      @(posedge clk);
      wr <= wn;
      rd <= !wn;
      addr <= a;
      wdata <= d;
      if (!wn) exp_q.push_back(d);
   endtask

   // Release the strobes, let n edges pass, then sample at the falling edge
   task automatic idle(input int n);
      @(posedge clk);
      wr <= 1'b0;
      rd <= 1'b0;
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask

   task automatic setm(input pioa_mode_t m);
      @(posedge clk);
      mode <= m;
   endtask

   task automatic test_done();
      $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   // Read data stand only in the cycle after the strobe
   always @(posedge clk) rd_d <= rd;
   always @(negedge clk) begin
      if (rd_d) check(rdata, exp_q.pop_front());
   end

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         fail_count++;
         test_done();
      end
   end

   initial begin
      v = 8'($urandom(32'he8bf));
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      idle(1);
      acc(0, `PIOA_OFF_DIR, `PIOA_DIR_RD_VAL);
      acc(0, `PIOA_OFF_LATCH, `PIOA_RST_LATCH);
      acc(0, `PIOA_OFF_PULLUP, `PIOA_RST_PULLUP);
      acc(0, `PIOA_OFF_ODRAIN, `PIOA_RST_ODRAIN);
      acc(0, 16'hFF60, `PIOA_UNMAPPED_RD);
      ext_en <= 8'hFF;
      ext_val <= v;
      lat = 8'($urandom);
      abus <= 8'($urandom);
      acc(1, `PIOA_OFF_LATCH, lat);
      acc(1, `PIOA_OFF_LEVEL, ~v);
      acc(1, 16'hFF68, ~lat);
      idle(3);
      acc(0, `PIOA_OFF_LEVEL, v);
      acc(0, `PIOA_OFF_LATCH, lat);
      acc(1, `PIOA_OFF_DIR, 8'h0F);
      acc(1, `PIOA_OFF_PULLUP, 8'hFF);
      ext_en <= 8'hF0;
      idle(1);
      // Modes 1 to 7 with direction 0F and all pull-ups enabled
      foreach (mt[i]) begin
         setm(mt[i]);
         idle(3);
         ad = (mt[i] == 3'h4 || mt[i] == 3'h5);
         eoe = ad ? 8'h1F : 8'h0F;
         check(pin_oe, eoe);
         check(pin_out & eoe, (ad || mt[i] == 3'h6) ? abus & eoe : lat & eoe);
         check(pu_on, ad ? 8'hE0 : 8'hF0);
         check({4'h0, irq}, {4'h0, v[7:5], (ad ? abus[4] : v[4])});
      end
      acc(0, `PIOA_OFF_LEVEL, {v[7:4], lat[3:0]});
      // Address pins across software standby, kept then floated
      keep <= 1'b1;
      sw_stby <= 1'b1;
      idle(3);
      w = pin_out;
      @(posedge clk);
      abus <= ~abus;
      idle(3);
      check(pin_oe, 8'h0F);
      check(pin_out & 8'h0F, w & 8'h0F);
      acc(0, `PIOA_OFF_LATCH, lat);
      sw_stby <= 1'b0;
      idle(3);
      @(posedge clk);
      keep <= 1'b0;
      sw_stby <= 1'b1;
      idle(3);
      check(pin_oe, 8'h00);
      @(posedge clk);
      sw_stby <= 1'b0;
      setm(3'h1);
      acc(1, `PIOA_OFF_ODRAIN, 8'h0F);
      acc(1, `PIOA_OFF_LATCH, 8'h05);
      acc(0, `PIOA_OFF_LATCH, 8'h05);
      idle(3);
      check(pin_oe, 8'h0A);
      check(pin_out & 8'h0A, 8'h00);
      // Pin-state register frozen by manual reset
      acc(1, `PIOA_OFF_DIR, 8'h00);
      ext_en <= 8'hFF;
      idle(4);
      acc(0, `PIOA_OFF_LEVEL, v);
      man_rst <= 1'b1;
      ext_val <= ~v;
      idle(4);
      acc(0, `PIOA_OFF_LEVEL, v);
      acc(0, `PIOA_OFF_ODRAIN, 8'h0F);
      acc(1, `PIOA_OFF_DIR, 8'hFF);
      man_rst <= 1'b0;
      idle(3);
      check(pin_oe, 8'hFA);
      // Hardware standby clears every writable register
      @(posedge clk);
      hw_stby <= 1'b1;
      idle(5);
      check(pin_oe, 8'h00);
      check(pu_on, 8'h00);
      @(posedge clk);
      hw_stby <= 1'b0;
      idle(4);
      check(pin_oe, 8'h00);
      acc(0, `PIOA_OFF_LATCH, `PIOA_RST_LATCH);
      acc(0, `PIOA_OFF_PULLUP, `PIOA_RST_PULLUP);
      acc(0, `PIOA_OFF_ODRAIN, `PIOA_RST_ODRAIN);
      acc(0, `PIOA_OFF_LEVEL, ~v);
      idle(3);
      test_done();
   end
endmodule
`default_nettype wire
